// File: src/ccm_core.sv
`timescale 1ns/1ps
`include "ccm_map.svh"
// Behaviour
// - sixteen 15-bit return entries, own memory
// - overflow/underflow flags, optional soft reset
// - two 16-bit pointers reach all memory
// - program-memory indirect access costs one extra cycle
// - 15-bit pc wraps within implemented memory
// - memory ends 0FFFh small, 1FFFh large
// - reset vector 0000h, interrupt vector 0004h
// - pointer high bit 7 selects program memory
// - program word read gives low eight bits
// - indirect writes never change program memory
// - data memory is 32 banks of 128
// - core, special, general and common areas
// - direct accesses use the bank register
// - unimplemented data locations read zero
// - 12-bit address, bank above, offset below
// - core registers at offsets 00h to 0Bh
// - flag-updating write to status keeps computed flags
// - timeout and powerdown flags are read-only
// - status layout, upper three bits zero
// - watchdog, sleep and power-up steer timeout/powerdown
// - zero on zero result, digit carry bit 3
// - carry from msb, inverted borrow, rotates
module ccm_core #(
    parameter bit LARGE_VARIANT = 1'b0
) (
    // clock and reset
    input  wire logic               clk_sys,
    input  wire logic               arst_n,
    input  wire logic               clk_en,
    // file-register access
    input  wire ccm_pkg::ccm_req_s  req,
    output logic [7:0]              rd_data,
    output logic                    rd_valid,
    output logic                    busy,
    // program memory read port
    output logic                    pm_rd,
    output logic [14:0]             pm_addr,
    input  wire logic [13:0]        pm_rdata,
    // arithmetic flags
    input  wire ccm_pkg::ccm_alu_s  alu,
    output logic [7:0]              alu_result,
    output logic                    alu_done,
    // program flow
    input  wire logic               step,
    input  wire logic               jump_valid,
    input  wire logic               call_valid,
    input  wire logic [14:0]        target_addr,
    input  wire logic               ret_valid,
    input  wire logic               int_take,
    output logic [14:0]             pc,
    output logic [4:0]              stack_depth,
    // power control
    input  wire logic               stack_reset_en,
    input  wire logic [1:0]         stack_flags_clr,
    input  wire logic               watchdog_clear_instr,
    input  wire logic               sleep_exec,
    input  wire logic               watchdog_timeout,
    output logic                    stack_overflow_flag,
    output logic                    stack_underflow_flag,
    output logic                    soft_reset,
    output logic [7:0]              core_status
);
    localparam logic [14:0] PM_LAST = LARGE_VARIANT ? `CCM_PM_LAST_LARGE : `CCM_PM_LAST_SMALL;
    ccm_pkg::ccm_state_s s;
    ccm_pkg::ccm_state_s n;
    logic [15:0] ind_ptr;
    logic        to_pm;
    logic [4:0]  acc_bank;
    logic [6:0]  acc_ofs;
    logic [8:0]  acc_slot;
    logic        take;
    ////////////////////////////////////////////////////////////////////////////////
    // helpers
    // wrap any address into the implemented program space
    function automatic logic [14:0] pm_wrap(input logic [14:0] a);
        return a & PM_LAST;
    endfunction
    // bit 8 flags a backed byte, bits 7:0 index the ram array
    function automatic logic [8:0] ram_slot(input logic [4:0] bnk, input logic [6:0] ofs);
        logic [8:0] r;
        r = 9'h000;
        if (ofs >= `CCM_OFS_COMMON_FIRST) begin
            // common bytes shared by every bank
            r = {1'b1, 8'(`CCM_GPR_BANKS * `CCM_GPR_BYTES) + 8'(ofs - `CCM_OFS_COMMON_FIRST)};
        end else if (ofs >= `CCM_OFS_GPR_FIRST && bnk < 5'(`CCM_GPR_BANKS)) begin
            r = {1'b1, 8'(bnk) * 8'(`CCM_GPR_BYTES) + 8'(ofs - `CCM_OFS_GPR_FIRST)};
        end
        return r;
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    // address resolution
    // pointer address: bank in 11:7, offset in 6:0
    assign ind_ptr  = s.ptr[req.ptr_sel];
    assign to_pm    = req.indirect & ind_ptr[`CCM_PM_SELECT_BIT];
    assign acc_bank = req.indirect ? ind_ptr[11:7] : s.bank;
    assign acc_ofs  = req.indirect ? ind_ptr[6:0] : req.offset;
    assign acc_slot = ram_slot(acc_bank, acc_ofs);
    assign take     = clk_en & req.valid & (s.fsm == ccm_pkg::CCM_IDLE);
    ////////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        logic       do_rst;
        logic [8:0] sum9;
        logic [4:0] nib5;
        logic [7:0] res;
        logic [2:0] fmask;
        logic [2:0] fval;
        logic [7:0] rd;
        logic [14:0] pc_inc;
        do_rst = 1'b0;
        sum9   = 9'h000;
        nib5   = 5'h00;
        res    = 8'h00;
        fmask  = 3'h0;
        fval   = 3'h0;
        rd     = 8'h00;
        pc_inc = pm_wrap(s.pc + 15'h0001);
        n      = s;
        if (clk_en) begin
            n.rvalid   = 1'b0;
            n.soft_rst = 1'b0;
            n.alu_done = 1'b0;
            // sticky stack flags: software clear first so a same-cycle event wins
            n.ovf = s.ovf & ~stack_flags_clr[0];
            n.unf = s.unf & ~stack_flags_clr[1];
            // second cycle of a program-memory indirect access
            case (s.fsm)
                ccm_pkg::CCM_IDLE: begin
                    n.fsm = ccm_pkg::CCM_IDLE;
                end
                ccm_pkg::CCM_PM_READ: begin
                    n.rdata  = pm_rdata[7:0];
                    n.rvalid = 1'b1;
                    n.pm_rd  = 1'b0;
                    n.busy   = 1'b0;
                    n.fsm    = ccm_pkg::CCM_IDLE;
                end
                ccm_pkg::CCM_PM_SKIP: begin
                    n.busy = 1'b0;
                    n.fsm  = ccm_pkg::CCM_IDLE;
                end
                default: begin
                    n.fsm = ccm_pkg::CCM_IDLE;
                end
            endcase
            // return stack and program counter, interrupt before call
            if (int_take || call_valid) begin
                if (s.depth == `CCM_STACK_DEPTH) begin
                    n.ovf  = 1'b1;
                    do_rst = stack_reset_en;
                end else begin
                    n.stack[s.depth[3:0]] = int_take ? s.pc : pc_inc;
                    n.depth = s.depth + 5'h01;
                    n.pc    = int_take ? `CCM_INT_VEC : pm_wrap(target_addr);
                end
            end else if (ret_valid) begin
                if (s.depth == 5'h00) begin
                    n.unf  = 1'b1;
                    do_rst = stack_reset_en;
                    n.pc   = pc_inc;
                end else begin
                    n.depth = s.depth - 5'h01;
                    n.pc    = s.stack[4'(s.depth - 5'h01)];
                end
            end else if (jump_valid) begin
                n.pc = pm_wrap(target_addr);
            end else if (step) begin
                n.pc = pc_inc;
            end
            // file-register access
            if (take && to_pm) begin
                // extra cycle; writes never reach program memory
                n.busy    = 1'b1;
                n.pm_addr = pm_wrap(ind_ptr[14:0]);
                n.pm_rd   = ~req.write;
                n.fsm     = req.write ? ccm_pkg::CCM_PM_SKIP : ccm_pkg::CCM_PM_READ;
            end else if (take) begin
                // core registers sit at the bottom of every bank
                case (acc_ofs)
                    `CCM_OFS_PC_LOW:            rd = s.pc[7:0];
                    `CCM_OFS_CORE_STATUS:       rd = {3'h0, s.tmo, s.pdn, s.zero, s.dcarry,
                                                      s.carry};
                    `CCM_OFS_POINTER0_LOW:      rd = s.ptr[0][7:0];
                    `CCM_OFS_POINTER0_HIGH:     rd = s.ptr[0][15:8];
                    `CCM_OFS_POINTER1_LOW:      rd = s.ptr[1][7:0];
                    `CCM_OFS_POINTER1_HIGH:     rd = s.ptr[1][15:8];
                    `CCM_OFS_BANK_SELECT:       rd = {3'h0, s.bank};
                    `CCM_OFS_WORKING_REGISTER:  rd = s.working_register;
                    `CCM_OFS_PC_LATCH_HIGH:     rd = s.pc_latch;
                    `CCM_OFS_INTERRUPT_CONTROL: rd = s.int_ctl;
                    default:                    rd = acc_slot[8] ? s.ram[acc_slot[7:0]] : 8'h00;
                endcase
                if (req.write) begin
                    case (acc_ofs)
                        `CCM_OFS_PC_LOW: n.pc = pm_wrap({s.pc_latch[6:0], req.wdata});
                        `CCM_OFS_CORE_STATUS: begin
                            // timeout and powerdown are not writable
                            n.zero   = req.wdata[`CCM_ST_ZERO];
                            n.dcarry = req.wdata[`CCM_ST_DIGIT_CARRY];
                            n.carry  = req.wdata[`CCM_ST_CARRY];
                        end
                        `CCM_OFS_POINTER0_LOW:      n.ptr[0][7:0]  = req.wdata;
                        `CCM_OFS_POINTER0_HIGH:     n.ptr[0][15:8] = req.wdata;
                        `CCM_OFS_POINTER1_LOW:      n.ptr[1][7:0]  = req.wdata;
                        `CCM_OFS_POINTER1_HIGH:     n.ptr[1][15:8] = req.wdata;
                        `CCM_OFS_BANK_SELECT:       n.bank = req.wdata[4:0];
                        `CCM_OFS_WORKING_REGISTER:  n.working_register = req.wdata;
                        `CCM_OFS_PC_LATCH_HIGH:     n.pc_latch = req.wdata;
                        `CCM_OFS_INTERRUPT_CONTROL: n.int_ctl = req.wdata;
                        default: begin
                            if (acc_slot[8]) begin
                                n.ram[acc_slot[7:0]] = req.wdata;
                            end
                        end
                    endcase
                end else begin
                    n.rdata  = rd;
                    n.rvalid = 1'b1;
                end
            end
            // flags from the arithmetic result; fmask/fval order is zero, dc, carry
            case (alu.op)
                ccm_pkg::CCM_ALU_ADD: begin
                    sum9  = {1'b0, alu.a} + {1'b0, alu.b};
                    nib5  = {1'b0, alu.a[3:0]} + {1'b0, alu.b[3:0]};
                    res   = sum9[7:0];
                    fmask = 3'h7;
                    fval  = {res == 8'h00, nib5[4], sum9[8]};
                end
                ccm_pkg::CCM_ALU_SUB: begin
                    // two's complement add, so carries read as inverted borrows
                    sum9  = {1'b0, alu.a} + {1'b0, ~alu.b} + 9'h001;
                    nib5  = {1'b0, alu.a[3:0]} + {1'b0, ~alu.b[3:0]} + 5'h01;
                    res   = sum9[7:0];
                    fmask = 3'h7;
                    fval  = {res == 8'h00, nib5[4], sum9[8]};
                end
                ccm_pkg::CCM_ALU_LOGIC: begin
                    res   = alu.b;
                    fmask = 3'h4;
                    fval  = {res == 8'h00, 2'h0};
                end
                ccm_pkg::CCM_ALU_ROT_LEFT: begin
                    res   = {alu.a[6:0], s.carry};
                    fmask = 3'h1;
                    fval  = {2'h0, alu.a[7]};
                end
                ccm_pkg::CCM_ALU_ROT_RIGHT: begin
                    res   = {s.carry, alu.a[7:1]};
                    fmask = 3'h1;
                    fval  = {2'h0, alu.a[0]};
                end
                default: begin
                    res   = 8'h00;
                    fmask = 3'h0;
                end
            endcase
            if (alu.op != ccm_pkg::CCM_ALU_NONE) begin
                n.alu_res  = res;
                n.alu_done = 1'b1;
                if (alu.to_status) begin
                    // result lands only in the flags the operation does not own
                    n.zero   = res[`CCM_ST_ZERO];
                    n.dcarry = res[`CCM_ST_DIGIT_CARRY];
                    n.carry  = res[`CCM_ST_CARRY];
                end
                n.zero   = fmask[2] ? fval[2] : n.zero;
                n.dcarry = fmask[1] ? fval[1] : n.dcarry;
                n.carry  = fmask[0] ? fval[0] : n.carry;
            end
            // reset-status flags; a time-out overrides the instructions
            if (watchdog_clear_instr) begin
                n.tmo = 1'b1;
                n.pdn = 1'b1;
            end else if (sleep_exec) begin
                n.tmo = 1'b1;
                n.pdn = 1'b0;
            end
            if (watchdog_timeout) begin
                n.tmo = 1'b0;
            end
            // soft reset restarts flow but keeps the flags readable
            if (do_rst) begin
                n.pc       = `CCM_RESET_VEC;
                n.depth    = 5'h00;
                n.fsm      = ccm_pkg::CCM_IDLE;
                n.busy     = 1'b0;
                n.pm_rd    = 1'b0;
                n.rvalid   = 1'b0;
                n.soft_rst = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // state register; ram content is left zeroed at power-on for determinism
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s          <= '0;
            s.pc       <= `CCM_RESET_VEC;
            s.tmo      <= `CCM_RST_TIMEOUT;
            s.pdn      <= `CCM_RST_POWERDOWN;
            s.zero     <= `CCM_RST_ARITH;
            s.dcarry   <= `CCM_RST_ARITH;
            s.carry    <= `CCM_RST_ARITH;
            s.ptr      <= {`CCM_RST_POINTER, `CCM_RST_POINTER};
            s.working_register     <= `CCM_RST_BYTE;
            s.fsm      <= ccm_pkg::CCM_IDLE;
        end else begin
            s <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs
    assign rd_data              = s.rdata;
    assign rd_valid             = s.rvalid;
    assign busy                 = s.busy;
    assign pm_rd                = s.pm_rd;
    assign pm_addr              = s.pm_addr;
    assign alu_result           = s.alu_res;
    assign alu_done             = s.alu_done;
    assign pc                   = s.pc;
    assign stack_depth          = s.depth;
    assign stack_overflow_flag  = s.ovf;
    assign stack_underflow_flag = s.unf;
    assign soft_reset           = s.soft_rst;
    assign core_status          = {3'h0, s.tmo, s.pdn, s.zero, s.dcarry, s.carry};
    ////////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    sequence pm_read_taken;
        take && to_pm && !req.write && !int_take && !call_valid && !ret_valid;
    endsequence
    sequence pm_read_done;
        pm_rd && busy && clk_en ##1 rd_valid && !busy;
    endsequence
    stack_bound_a: assert property (s.depth <= `CCM_STACK_DEPTH)
        else $error("stack depth beyond sixteen");
    stack_ovf_a: assert property ((clk_en && (int_take || call_valid)
                                   && s.depth == `CCM_STACK_DEPTH)
                                  |=> stack_overflow_flag && soft_reset == $past(stack_reset_en))
        else $error("overflow not flagged");
    stack_unf_a: assert property ((clk_en && ret_valid && !int_take && !call_valid
                                   && s.depth == 5'h00) |=> stack_underflow_flag)
        else $error("underflow not flagged");
    pm_extra_cycle_a: assert property (pm_read_taken |=> pm_read_done)
        else $error("program memory read not one cycle late");
    pm_low_byte_a: assert property ((pm_rd && clk_en) |=> rd_data == $past(pm_rdata[7:0]))
        else $error("program word low byte not returned");
    pc_wrap_a: assert property (pc <= PM_LAST)
        else $error("pc outside implemented memory");
    int_vector_a: assert property ((clk_en && int_take && s.depth < `CCM_STACK_DEPTH)
                                   |=> pc == `CCM_INT_VEC && stack_depth == $past(s.depth) + 5'h01)
        else $error("interrupt vector not taken");
    status_ro_a: assert property ((clk_en && !watchdog_clear_instr && !sleep_exec
                                   && !watchdog_timeout) |=> $stable(core_status[4:3]))
        else $error("timeout or powerdown changed");
    flag_sticky_a: assert property ((stack_overflow_flag && !(clk_en && stack_flags_clr[0]))
                                    |=> stack_overflow_flag)
        else $error("overflow flag lost");
    soft_rst_a: assert property (soft_reset |-> pc == `CCM_RESET_VEC && stack_depth == 5'h00)
        else $error("soft reset did not restart");
endmodule

// File: src/ccm_map.svh
`ifndef CCM_MAP_SVH
`define CCM_MAP_SVH

// core register offsets inside every bank
`define CCM_OFS_INDIRECT_DATA_0   7'h00
`define CCM_OFS_INDIRECT_DATA_1   7'h01
`define CCM_OFS_PC_LOW            7'h02
`define CCM_OFS_CORE_STATUS       7'h03
`define CCM_OFS_POINTER0_LOW      7'h04
`define CCM_OFS_POINTER0_HIGH     7'h05
`define CCM_OFS_POINTER1_LOW      7'h06
`define CCM_OFS_POINTER1_HIGH     7'h07
`define CCM_OFS_BANK_SELECT       7'h08
`define CCM_OFS_WORKING_REGISTER  7'h09
`define CCM_OFS_PC_LATCH_HIGH     7'h0A
`define CCM_OFS_INTERRUPT_CONTROL 7'h0B

// bank layout
`define CCM_OFS_GPR_FIRST         7'h20
`define CCM_OFS_COMMON_FIRST      7'h70
`define CCM_GPR_BYTES             80
`define CCM_GPR_BANKS             2
`define CCM_COMMON_BYTES          16
`define CCM_RAM_BYTES             176

// core_status field positions
`define CCM_ST_TIMEOUT            4
`define CCM_ST_POWERDOWN          3
`define CCM_ST_ZERO               2
`define CCM_ST_DIGIT_CARRY        1
`define CCM_ST_CARRY              0

// reset values
`define CCM_RST_TIMEOUT           1'b1
`define CCM_RST_POWERDOWN         1'b1
`define CCM_RST_ARITH             1'b0
`define CCM_RST_BYTE              8'h00
`define CCM_RST_POINTER           16'h0000

// program space
`define CCM_STACK_DEPTH           5'h10
`define CCM_RESET_VEC             15'h0000
`define CCM_INT_VEC               15'h0004
`define CCM_PM_LAST_SMALL         15'h0FFF
`define CCM_PM_LAST_LARGE         15'h1FFF
`define CCM_PM_SELECT_BIT         15

`endif

// File: src/ccm_pkg.sv
package ccm_pkg;
`include "ccm_map.svh"

    // arithmetic operation presented by instruction execution
    typedef enum logic [2:0] {
        CCM_ALU_NONE,
        CCM_ALU_ADD,
        CCM_ALU_SUB,
        CCM_ALU_LOGIC,
        CCM_ALU_ROT_LEFT,
        CCM_ALU_ROT_RIGHT
    } ccm_alu_op_e;

    typedef enum logic [1:0] {
        CCM_IDLE,
        CCM_PM_READ,
        CCM_PM_SKIP
    } ccm_fsm_e;

    // one file-register access
    typedef struct packed {
        logic       valid;
        logic       write;
        logic       indirect;
        logic       ptr_sel;
        logic [6:0] offset;
        logic [7:0] wdata;
    } ccm_req_s;

    // one arithmetic/logic result to flag
    typedef struct packed {
        ccm_alu_op_e op;
        logic [7:0]  a;
        logic [7:0]  b;
        logic        to_status;
    } ccm_alu_s;

    typedef struct packed {
        logic [15:0][14:0]                 stack;
        logic [4:0]                        depth;
        logic [14:0]                       pc;
        logic [7:0]                        pc_latch;
        logic [7:0]                        int_ctl;
        logic [7:0]                        working_register;
        logic [4:0]                        bank;
        logic [1:0][15:0]                  ptr;
        logic                              tmo;
        logic                              pdn;
        logic                              zero;
        logic                              dcarry;
        logic                              carry;
        logic                              ovf;
        logic                              unf;
        logic                              soft_rst;
        logic [`CCM_RAM_BYTES-1:0][7:0]    ram;
        ccm_fsm_e                          fsm;
        logic                              busy;
        logic                              pm_rd;
        logic [14:0]                       pm_addr;
        logic [7:0]                        rdata;
        logic                              rvalid;
        logic [7:0]                        alu_res;
        logic                              alu_done;
    } ccm_state_s;

endpackage

// File: verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic                clk_sys = 1'b0;
    logic                arst_n = 1'b0;
    ccm_pkg::ccm_req_s   req = '0;
    ccm_pkg::ccm_alu_s   alu = '0;
    logic [13:0]         pm_rdata = 14'h3A5C;
    logic [14:0]         tgt = 15'h0100;
    // strobes: step jump call ret int wdclr sleep wdto rst_en clr[1:0]
    logic [10:0]         ctl = '0;
    logic [7:0]          rd_data, alu_result, core_status;
    logic                rd_valid, busy, pm_rd, alu_done, ovf, unf, srst, pr, bz;
    logic [14:0]         pm_addr, pc, pa;
    logic [4:0]          depth;
    logic [2:0]          lat;
    logic                ts = 1'b0;
    int                  n_fail = 0;
    int                  checks_done = 0;

    always #25 clk_sys = ~clk_sys;

    ccm_core #(.LARGE_VARIANT(1'b0)) uut (
        .clk_sys(clk_sys), .arst_n(arst_n), .clk_en(1'b1), .req(req), .rd_data(rd_data),
        .rd_valid(rd_valid), .busy(busy), .pm_rd(pm_rd), .pm_addr(pm_addr),
        .pm_rdata(pm_rdata), .alu(alu), .alu_result(alu_result), .alu_done(alu_done),
        .step(ctl[0]), .jump_valid(ctl[1]), .call_valid(ctl[2]), .target_addr(tgt),
        .ret_valid(ctl[3]), .int_take(ctl[4]), .pc(pc), .stack_depth(depth),
        .stack_reset_en(ctl[8]), .stack_flags_clr(ctl[10:9]),
        .watchdog_clear_instr(ctl[5]), .sleep_exec(ctl[6]), .watchdog_timeout(ctl[7]),
        .stack_overflow_flag(ovf), .stack_underflow_flag(unf), .soft_reset(srst),
        .core_status(core_status));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d errors %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // one access; lat counts cycles beyond the plain one, 4 means no answer
    task automatic acc(input logic w, i, s, input logic [6:0] o, input logic [7:0] d);
        @(posedge clk_sys);
        req <= '{1'b1, w, i, s, o, d};
        @(posedge clk_sys);
        req <= '0;
        #1;
        {pr, bz, pa, lat} = {pm_rd, busy, pm_addr, 3'd0};
        while (!w && rd_valid !== 1'b1 && lat < 4) begin
            @(posedge clk_sys);
            #1;
            lat++;
        end
    endtask

    task automatic wr(input logic [6:0] o, input logic [7:0] d);
        acc(1'b1, 1'b0, 1'b0, o, d);
    endtask

    task automatic rd(input logic [6:0] o, input logic [7:0] e);
        acc(1'b0, 1'b0, 1'b0, o, 8'h00);
        chk({lat, rd_data}, {3'd0, e});
    endtask

    // strobes last exactly one enabled cycle
    task automatic pulse(input logic [10:0] v);
        @(posedge clk_sys);
        ctl <= v;
        @(posedge clk_sys);
        ctl <= '0;
        #1;
    endtask

    task automatic op(input ccm_pkg::ccm_alu_op_e o, input logic [7:0] a, b, r, st);
        @(posedge clk_sys);
        alu <= '{o, a, b, ts};
        @(posedge clk_sys);
        alu <= '0;
        #1;
        chk({alu_done, alu_result, core_status}, {1'b1, r, st});
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // cut a hang short; the whole run is under two hundred cycles
    initial begin
        #50000;
        n_fail++;
        end_sim();
    end

    initial begin
        repeat (16) @(posedge clk_sys);
        chk({pc, depth, core_status}, {15'h0000, 5'd0, 8'h18});
        arst_n <= 1'b1;
        pulse(11'h040);
        chk(core_status, 8'h10);
        pulse(11'h080);
        chk(core_status, 8'h00);
        pulse(11'h020);
        chk(core_status, 8'h18);
        pulse(11'h004);
        pulse(11'h010);
        chk({pc, depth}, {15'h0004, 5'd2});
        pulse(11'h008);
        pulse(11'h008);
        chk({pc, depth}, {15'h0001, 5'd0});
        tgt <= 15'h0FFF;
        pulse(11'h002);
        pulse(11'h001);
        chk(pc, 15'h0000);
        tgt <= 15'h0100;
        repeat (17) pulse(11'h004);
        chk({ovf, depth, pc}, {1'b1, 5'd16, 15'h0100});
        pulse(11'h200);
        chk(ovf, 1'b0);
        repeat (17) pulse(11'h008);
        chk({unf, depth, srst}, {1'b1, 5'd0, 1'b0});
        pulse(11'h108);
        chk({unf, srst}, 2'b11);
        pulse(11'h020);
        op(ccm_pkg::CCM_ALU_ADD, 8'h0F, 8'h01, 8'h10, 8'h1A);
        op(ccm_pkg::CCM_ALU_SUB, 8'h00, 8'h01, 8'hFF, 8'h18);
        op(ccm_pkg::CCM_ALU_ADD, 8'hFF, 8'h01, 8'h00, 8'h1F);
        op(ccm_pkg::CCM_ALU_LOGIC, 8'h00, 8'h5A, 8'h5A, 8'h1B);
        op(ccm_pkg::CCM_ALU_ROT_LEFT, 8'h80, 8'h00, 8'h01, 8'h1B);
        op(ccm_pkg::CCM_ALU_ROT_RIGHT, 8'h02, 8'h00, 8'h81, 8'h1A);
        wr(7'h03, 8'hE0);
        rd(7'h03, 8'h18);
        wr(7'h08, 8'h01);
        wr(7'h20, 8'hAA);
        wr(7'h70, 8'hC3);
        wr(7'h08, 8'h00);
        wr(7'h20, 8'h55);
        rd(7'h70, 8'hC3);
        rd(7'h08, 8'h00);
        wr(7'h08, 8'h01);
        rd(7'h20, 8'hAA);
        wr(7'h08, 8'h03);
        rd(7'h20, 8'h00);
        wr(7'h05, 8'h00);
        wr(7'h04, 8'h20);
        acc(1'b0, 1'b1, 1'b0, 7'h00, 8'h00);
        chk(rd_data, 8'h55);
        wr(7'h05, 8'h81);
        wr(7'h04, 8'h23);
        acc(1'b0, 1'b1, 1'b0, 7'h00, 8'h00);
        chk({lat, bz, pr, pa, rd_data}, {3'd1, 2'b11, 15'h0123, 8'h5C});
        wr(7'h06, 8'hFF);
        wr(7'h07, 8'hFF);
        acc(1'b0, 1'b1, 1'b1, 7'h01, 8'h00);
        chk(pa, 15'h0FFF);
        acc(1'b1, 1'b1, 1'b0, 7'h00, 8'h77);
        chk({bz, pr}, 2'b10);
        ts <= 1'b1;
        op(ccm_pkg::CCM_ALU_LOGIC, 8'h00, 8'h03, 8'h03, 8'h1B);
        end_sim();
    end
endmodule
